// file: design/dso_pkg.sv
// package: function codes, terminal counts, pulse timing and status carrier
package dso_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned PULSE_WIDTH_MS = 250;
  localparam int unsigned PULSE_CYCLES = (CLK_HZ / 1000) * PULSE_WIDTH_MS;

  // ==========================================================================
  // terminal counts
  localparam int unsigned NUM_OC = 2;
  localparam int unsigned NUM_RELAY = 1;
  localparam int unsigned NUM_VIRT = 5;
  localparam int unsigned NUM_TERM = NUM_OC + NUM_RELAY + NUM_VIRT;
  localparam int unsigned CODE_W = 5;

  // ==========================================================================
  // function codes
  localparam logic [4:0] FC_NONE = 5'h00;
  localparam logic [4:0] FC_RUN = 5'h01;
  localparam logic [4:0] FC_FREQ_ARRIVED = 5'h02;
  localparam logic [4:0] FC_FDT_A = 5'h03;
  localparam logic [4:0] FC_FDT_B = 5'h04;
  localparam logic [4:0] FC_RESERVED5 = 5'h05;
  localparam logic [4:0] FC_UNDERVOLT = 5'h06;
  localparam logic [4:0] FC_EXT_FAULT = 5'h07;
  localparam logic [4:0] FC_UPPER_LIM = 5'h08;
  localparam logic [4:0] FC_LOWER_LIM = 5'h09;
  localparam logic [4:0] FC_ZERO_FREQ = 5'h0A;
  localparam logic [4:0] FC_SEQ_STAGE = 5'h0B;
  localparam logic [4:0] FC_SEQ_CYCLE = 5'h0C;
  localparam logic [4:0] FC_COUNT_SET = 5'h0D;
  localparam logic [4:0] FC_COUNT_SPEC = 5'h0E;
  localparam logic [4:0] FC_LENGTH = 5'h0F;
  localparam logic [4:0] FC_READY = 5'h10;
  localparam logic [4:0] FC_FAULT = 5'h11;

  // fast pulse pin modes
  localparam logic FAST_MODE_SWITCH = 1'b0;
  localparam logic FAST_MODE_PULSE = 1'b1;

  // reset values
  localparam logic [4:0] CODE_RESET = 5'h00;

  // ==========================================================================
  // drive status carrier
  typedef struct packed {
    logic running;
    logic frequency_arrived_flag;
    logic freq_level_detect_a;
    logic freq_level_detect_b;
    logic undervoltage_lockout_flag;
    logic external_fault_stop_flag;
    logic set_ge_upper;
    logic at_upper;
    logic set_le_lower;
    logic at_lower;
    logic out_le_zero_range;
    logic seq_stage_done;
    logic seq_cycle_done;
    logic count_set_reached;
    logic count_spec_reached;
    logic length_reached;
    logic ready;
    logic fault;
  } dso_status_t;

endpackage

// file: design/dso_output_select.sv
// drive status output selector for physical and virtual output terminals
`timescale 1ns/1ps

// Contract
// - There are two open-collector outputs, one relay output and five virtual outputs, each with a function code.
// - The fast pulse pin works either as a pulse output or as an ordinary switching output by its own mode select.
// - Code 0 keeps a terminal inactive whatever the drive status.
// - Code 1 asserts the terminal while the drive runs.
// - Code 6 asserts the terminal under bus undervoltage and shows the power-off text on the display.
// - Code 7 asserts the terminal while an external fault trip is active.
// - Code 8 asserts when set frequency is at or above the upper limit and output frequency has reached it.
// - Code 9 asserts when set frequency is at or below the lower limit and output frequency has reached it.
// - Code 10 asserts while running with output frequency within the zero-frequency range.
// - Code 11 gives one 250 ms pulse when a sequencer stage completes while no stage pulse is running.
// - Code 12 gives one 250 ms pulse when the sequencer completes a full cycle while no cycle pulse is running.
// - Code 15 asserts once the actual length reaches the set length.
// - Code 17 asserts the terminal while the drive is in a fault state.
module dso_output_select
  import dso_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // drive status and function codes
  input wire dso_status_t status,
  input wire logic [NUM_TERM*CODE_W-1:0] term_code,
  input wire logic fast_pin_mode,
  input wire logic fast_pulse_in,
  // terminal outputs
  output logic [NUM_OC-1:0] oc_out,
  output logic [NUM_RELAY-1:0] relay_out,
  output logic [NUM_VIRT-1:0] virtual_output_terminal,
  output logic fast_pulse_output_pin,
  output logic display_power_off
);

  // ==========================================================================
  // parameter check
  localparam int unsigned NUM_CODES = 1 << CODE_W;

  if (PULSE_LEN < 1) begin : g_bad_pulse
    $error("dso_output_select: pulse length must be at least one cycle");
  end
  if (NUM_TERM != 8 || CODE_W != 5) begin : g_bad_layout
    $error("dso_output_select: terminal layout must be eight 5-bit code fields");
  end
  if (NUM_OC < 1) begin : g_bad_fast
    $error("dso_output_select: fast pin needs open-collector terminal 0");
  end

  // ==========================================================================
  // sequencer completion pulse stretchers
  localparam int CW = $clog2(PULSE_LEN + 1);
  logic [CW-1:0] stage_cnt_r;
  logic [CW-1:0] cycle_cnt_r;
  logic [CW-1:0] stage_cnt_nxt;
  logic [CW-1:0] cycle_cnt_nxt;
  wire stage_pulse = (stage_cnt_r != '0);
  wire cycle_pulse = (cycle_cnt_r != '0);

  // a new completion while a pulse runs does not extend it and gets no pulse of its own
  assign stage_cnt_nxt = (status.seq_stage_done && !stage_pulse) ? CW'(PULSE_LEN) :
                         (stage_pulse ? stage_cnt_r - 1'b1 : stage_cnt_r);
  assign cycle_cnt_nxt = (status.seq_cycle_done && !cycle_pulse) ? CW'(PULSE_LEN) :
                         (cycle_pulse ? cycle_cnt_r - 1'b1 : cycle_cnt_r);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage_cnt_r <= '0;
      cycle_cnt_r <= '0;
    end else begin
      stage_cnt_r <= stage_cnt_nxt;
      cycle_cnt_r <= cycle_cnt_nxt;
    end
  end

  // ==========================================================================
  // condition decode
  wire cond_run = status.running;
  wire cond_uv = status.undervoltage_lockout_flag;
  wire cond_ext = status.external_fault_stop_flag;
  wire cond_upper = status.set_ge_upper && status.at_upper;
  wire cond_lower = status.set_le_lower && status.at_lower;
  wire cond_zero = status.running && status.out_le_zero_range;
  wire cond_len = status.length_reached;
  wire cond_fault = status.fault;

  // ==========================================================================
  // per-terminal selection
  wire [NUM_CODES-1:0] cond_vec;
  wire [NUM_TERM-1:0] sel_lvl;
  logic [NUM_TERM-1:0] term_r;

  // one condition per function code; reserved and undefined codes stay low
  assign cond_vec[FC_NONE] = 1'b0;
  assign cond_vec[FC_RUN] = cond_run;
  assign cond_vec[FC_FREQ_ARRIVED] = status.frequency_arrived_flag;
  assign cond_vec[FC_FDT_A] = status.freq_level_detect_a;
  assign cond_vec[FC_FDT_B] = status.freq_level_detect_b;
  assign cond_vec[FC_RESERVED5] = 1'b0;
  assign cond_vec[FC_UNDERVOLT] = cond_uv;
  assign cond_vec[FC_EXT_FAULT] = cond_ext;
  assign cond_vec[FC_UPPER_LIM] = cond_upper;
  assign cond_vec[FC_LOWER_LIM] = cond_lower;
  assign cond_vec[FC_ZERO_FREQ] = cond_zero;
  assign cond_vec[FC_SEQ_STAGE] = stage_pulse;
  assign cond_vec[FC_SEQ_CYCLE] = cycle_pulse;
  assign cond_vec[FC_COUNT_SET] = status.count_set_reached;
  assign cond_vec[FC_COUNT_SPEC] = status.count_spec_reached;
  assign cond_vec[FC_LENGTH] = cond_len;
  assign cond_vec[FC_READY] = status.ready;
  assign cond_vec[FC_FAULT] = cond_fault;
  assign cond_vec[NUM_CODES-1:FC_FAULT+1] = '0;

  for (genvar g = 0; g < NUM_TERM; g++) begin : g_term
    wire [CODE_W-1:0] code = term_code[g*CODE_W +: CODE_W];
    assign sel_lvl[g] = cond_vec[code];
  end

  // registered every cycle from the current selection
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      term_r <= '0;
    end else begin
      term_r <= sel_lvl;
    end
  end

  // ==========================================================================
  // terminal mapping and fast pin
  logic fast_r;
  logic uv_disp_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fast_r <= 1'b0;
      uv_disp_r <= 1'b0;
    end else begin
      fast_r <= (fast_pin_mode == FAST_MODE_PULSE) ? fast_pulse_in : sel_lvl[0];
      uv_disp_r <= cond_uv;
    end
  end

  // terminal 0 is the first open-collector output, shared with the fast pin
  assign oc_out = term_r[NUM_OC-1:0];
  assign relay_out = term_r[NUM_OC +: NUM_RELAY];
  assign virtual_output_terminal = term_r[NUM_OC+NUM_RELAY +: NUM_VIRT];
  assign fast_pulse_output_pin = fast_r;
  assign display_power_off = uv_disp_r;

endmodule

// file: tb/dso_load.sv
// load model: pulled-up open-collector lines and relay contact
`timescale 1ns/1ps
module dso_load
  import dso_pkg::*;
(
  // terminal drive
  input wire logic [NUM_OC-1:0] oc_on,
  input wire logic [NUM_RELAY-1:0] relay_on,
  // load side
  output logic [NUM_OC-1:0] oc_line,
  output logic [NUM_RELAY-1:0] relay_closed
);
  assign oc_line = ~oc_on;
  assign relay_closed = relay_on;
endmodule

// file: tb/dso_output_select_properties.sv
// assertion checker for the output selector
`timescale 1ns/1ps
module dso_props
  import dso_pkg::*;
#(parameter int unsigned PULSE_LEN = 10) (
  // watched ports
  input wire logic clk_sys,
  input wire logic reset,
  input wire dso_status_t status,
  input wire logic [NUM_TERM*CODE_W-1:0] term_code,
  input wire logic fast_pin_mode,
  input wire logic fast_pulse_in,
  input wire logic [NUM_OC-1:0] oc_out,
  input wire logic [NUM_RELAY-1:0] relay_out,
  input wire logic [NUM_VIRT-1:0] virtual_output_terminal,
  input wire logic fast_pulse_output_pin,
  input wire logic display_power_off
);
  // ==========
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [31:0] hi_cnt_r;
  always_ff @(posedge clk_sys) hi_cnt_r <= (reset || !oc_out[0]) ? 32'h0 : hi_cnt_r + 32'h1;
  property p_run; term_code[4:0] == FC_RUN |=> oc_out[0] == $past(status.running); endproperty
  a_run: assert property (p_run) else $error("run code wrong");
  property p_upper; term_code[9:5] == FC_UPPER_LIM |=> oc_out[1] == $past(status.set_ge_upper && status.at_upper); endproperty
  a_upper: assert property (p_upper) else $error("upper limit code wrong");
  property p_uv; term_code[14:10] == FC_UNDERVOLT |=> relay_out[0] == $past(status.undervoltage_lockout_flag); endproperty
  a_uv: assert property (p_uv) else $error("undervoltage code wrong");
  property p_none; term_code[14:10] == FC_NONE || term_code[14:10] == FC_RESERVED5 |=> !relay_out[0]; endproperty
  a_none: assert property (p_none) else $error("idle code drove output");
  property p_disp; 1'b1 |=> display_power_off == $past(status.undervoltage_lockout_flag); endproperty
  a_disp: assert property (p_disp) else $error("power-off display wrong");
  property p_fast; fast_pin_mode |=> fast_pulse_output_pin == $past(fast_pulse_in); endproperty
  a_fast: assert property (p_fast) else $error("fast pin not passing pulses");
  property p_switch; !fast_pin_mode |=> fast_pulse_output_pin == oc_out[0]; endproperty
  a_switch: assert property (p_switch) else $error("fast pin not following terminal 0");
  property p_rise; term_code[4:0] == FC_SEQ_STAGE && !oc_out[0] && status.seq_stage_done |-> ##[1:2] oc_out[0]; endproperty
  a_rise: assert property (p_rise) else $error("stage pulse missing");
  property p_width; $fell(oc_out[0]) && !$past(reset) && term_code[4:0] == FC_SEQ_STAGE |-> hi_cnt_r == PULSE_LEN; endproperty
  a_width: assert property (p_width) else $error("stage pulse width wrong");
endmodule
bind dso_output_select dso_props #(.PULSE_LEN(PULSE_LEN)) i_props (.clk_sys(clk_sys), .reset(reset), .status(status),
  .term_code(term_code), .fast_pin_mode(fast_pin_mode), .fast_pulse_in(fast_pulse_in), .oc_out(oc_out),
  .relay_out(relay_out), .virtual_output_terminal(virtual_output_terminal),
  .fast_pulse_output_pin(fast_pulse_output_pin), .display_power_off(display_power_off));

// file: tb/dso_output_select_test.sv
// self-checking bench for the output selector
`timescale 1ns/1ps
module dso_output_select_test
  import dso_pkg::*;
;
  localparam int unsigned PL = 10;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  dso_status_t status = '0;
  logic [NUM_TERM*CODE_W-1:0] term_code = '0;
  logic fast_pin_mode = 1'b0;
  logic fast_pulse_in = 1'b0;
  logic [NUM_OC-1:0] oc_out, oc_line;
  logic [NUM_RELAY-1:0] relay_out, relay_closed;
  logic [NUM_VIRT-1:0] virtual_output_terminal;
  logic fast_pulse_output_pin, display_power_off;
  int error_cnt = 0;
  int samples_checked = 0;
  // ==========
  // instances
  dso_output_select #(.PULSE_LEN(PL)) i_dut (.clk_sys(clk_sys), .reset(reset), .status(status),
    .term_code(term_code), .fast_pin_mode(fast_pin_mode), .fast_pulse_in(fast_pulse_in), .oc_out(oc_out),
    .relay_out(relay_out), .virtual_output_terminal(virtual_output_terminal),
    .fast_pulse_output_pin(fast_pulse_output_pin), .display_power_off(display_power_off));
  dso_load i_load (.oc_on(oc_out), .relay_on(relay_out), .oc_line(oc_line), .relay_closed(relay_closed));
  initial forever #4 clk_sys = ~clk_sys;
  // ==========
  // helpers
  task check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task finish_test;
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic lv(input logic [4:0] c, input dso_status_t s);
    case (c)
      FC_RUN: lv = s.running;
      FC_FREQ_ARRIVED: lv = s.frequency_arrived_flag;
      FC_FDT_A: lv = s.freq_level_detect_a;
      FC_FDT_B: lv = s.freq_level_detect_b;
      FC_UNDERVOLT: lv = s.undervoltage_lockout_flag;
      FC_EXT_FAULT: lv = s.external_fault_stop_flag;
      FC_UPPER_LIM: lv = s.set_ge_upper & s.at_upper;
      FC_LOWER_LIM: lv = s.set_le_lower & s.at_lower;
      FC_ZERO_FREQ: lv = s.running & s.out_le_zero_range;
      FC_COUNT_SET: lv = s.count_set_reached;
      FC_COUNT_SPEC: lv = s.count_spec_reached;
      FC_LENGTH: lv = s.length_reached;
      FC_READY: lv = s.ready;
      FC_FAULT: lv = s.fault;
      default: lv = 1'b0;
    endcase
  endfunction
  // ==========
  // scenarios
  task t_levels;
    dso_status_t s;
    logic [NUM_TERM*CODE_W-1:0] tc;
    logic [NUM_TERM-1:0] e;
    for (int c = 0; c < 32; c++) begin
      for (int p = 0; p < 20; p++) begin
        s = (p == 0) ? '0 : (p == 1) ? '1 : dso_status_t'(18'h1 << (p - 2));
        s.seq_stage_done = 1'b0;
        s.seq_cycle_done = 1'b0;
        for (int i = 0; i < NUM_TERM; i++) begin
          tc[i*CODE_W +: CODE_W] = 5'((c + i) % 32);
          e[i] = lv(5'((c + i) % 32), s);
        end
        @(posedge clk_sys);
        status <= s;
        term_code <= tc;
        @(posedge clk_sys);
        #1;
        check({display_power_off, fast_pulse_output_pin, virtual_output_terminal, relay_closed, ~oc_line},
          {s.undervoltage_lockout_flag, e[0], e}, "levels");
      end
    end
  endtask
  task t_pulse(input logic [4:0] c);
    int w;
    w = 0;
    @(posedge clk_sys);
    status <= '0;
    term_code <= {NUM_TERM{c}};
    @(posedge clk_sys);
    status.seq_stage_done <= (c == FC_SEQ_STAGE);
    status.seq_cycle_done <= (c == FC_SEQ_CYCLE);
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      status.seq_stage_done <= (k == 4) && (c == FC_SEQ_STAGE);
      status.seq_cycle_done <= (k == 4) && (c == FC_SEQ_CYCLE);
      #1;
      w += relay_closed[0];
    end
    check(16'(w), 16'(PL), "pulse width");
  endtask
  task t_fast;
    @(posedge clk_sys);
    fast_pin_mode <= FAST_MODE_PULSE;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys);
      fast_pulse_in <= k[0];
      @(posedge clk_sys);
      #1;
      check(16'(fast_pulse_output_pin), 16'(k[0]), "fast pin");
    end
  endtask
  task t_reset;
    int w;
    w = 0;
    @(posedge clk_sys);
    status <= '0;
    term_code <= {NUM_TERM{FC_SEQ_STAGE}};
    fast_pin_mode <= FAST_MODE_SWITCH;
    fast_pulse_in <= 1'b0;
    @(posedge clk_sys);
    status.seq_stage_done <= 1'b1;
    @(posedge clk_sys);
    status.seq_stage_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check(16'(relay_closed[0]), 16'h0001, "pulse before reset");
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    #1;
    check({display_power_off, fast_pulse_output_pin, virtual_output_terminal, relay_closed, ~oc_line}, 16'h0000,
      "outputs in reset");
    @(posedge clk_sys);
    reset <= 1'b0;
    repeat (PL + 2) begin
      @(posedge clk_sys);
      #1;
      w += relay_closed[0];
    end
    check(16'(w), 16'h0000, "pulse after reset");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_levels;
    t_pulse(FC_SEQ_STAGE);
    t_pulse(FC_SEQ_CYCLE);
    t_fast;
    t_reset;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    finish_test;
  end
endmodule
